/* File: core/rdsl_security_lock.sv */
`timescale 1ns/100ps
// Functional notes
// - Protect config: bit 0 enable, upper bits read zero.
// - Debug config: bit 0 debug off, upper bits read zero.
// - Enables reset to 1 only by power-on reset; system reset ignored.
// - Protect lock register is write-only; reads return zero.
// - Staged protect enable commits on key word write to lock register.
// - Active protection blocks protect config/lock access not fetched from ROM.
// - Staged debug-off commits on debug key word write.
// - Flash security input forces the access guard active whenever it is high.
// - Enable bits read back committed state, not staged value.
module rdsl_security_lock
  import rdsl_pkg::*;
(
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        powerOnReset,
  // Flash security state
  input  wire logic        flashSecure,
  // Register port
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  input  wire logic        fetchFromRom,
  output logic      [31:0] rdata,
  output logic             accessBlocked,
  // Effective security state
  output logic             romGuardOn,
  output logic             debugPortOff
);

  // Bus request as one bundle
  rdsl_req_t   req;

  // Committed state and its next value
  rdsl_state_t eff_r;
  rdsl_state_t eff_nxt;

  // Staged enables as written by software
  logic        romStage_r;
  logic        romStage_nxt;
  logic        dbgStage_r;
  logic        dbgStage_nxt;

  // Registered bus answer
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        blocked_r;
  logic        blocked_nxt;

  // Decode and qualifier nets
  logic        hitDbgCfg;
  logic        hitDbgKey;
  logic        hitRomCfg;
  logic        hitRomLock;
  logic        anyAccess;
  logic        guardActive;
  logic        romRegs;
  logic        outsideRom;
  logic        denied;
  logic        wrOk;
  logic        rdOk;
  logic        romStageWr;
  logic        dbgStageWr;
  logic        romLockWr;
  logic        dbgKeyWr;
  logic        romKeyOk;
  logic        dbgKeyOk;
  logic        romCommit;
  logic        dbgCommit;
  logic        romGuardNxt;
  logic        dbgOffNxt;
  logic [31:0] romCfgWord;
  logic [31:0] dbgCfgWord;
  logic [31:0] rdMux;

  // Bundle the port so decode reads one carrier
  assign req = '{addr: addr, wdata: wdata, wr: wrStrobe, rd: rdStrobe,
                 fromRom: fetchFromRom};

  // Full-word address match
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    return a == r;
  endfunction

  // Whole-word key compare; a near miss must not commit
  function automatic logic keyMatch(input logic [31:0] d,
                                    input logic [31:0] k);
    return d == k;
  endfunction

  // One enable bit in a zero-filled word
  function automatic logic [31:0] enableWord(input logic b);
    return {31'h00000000, b};
  endfunction

  // Register decode; full words only, byte lanes not decoded
  assign hitDbgCfg  = hit(req.addr, DEBUG_LOCK_CONFIG_ADDR);
  assign hitDbgKey  = hit(req.addr, DEBUG_LOCK_KEY_ADDR);
  assign hitRomCfg  = hit(req.addr, ROM_PROTECT_CONFIG_ADDR);
  assign hitRomLock = hit(req.addr, ROM_PROTECT_LOCK_ADDR);
  assign anyAccess  = req.wr | req.rd;

  // flash security forces guard
  // Live input, so guard follows flash state at once
  assign guardActive = eff_r.romGuardOn | flashSecure;

  // guard only from ROM
  // Debug registers are not guarded here
  assign romRegs    = hitRomCfg | hitRomLock;
  assign outsideRom = ~req.fromRom;
  assign denied     = romRegs & guardActive & outsideRom;
  assign wrOk       = req.wr & ~denied;
  assign rdOk       = req.rd & ~denied;

  // Write decode per register
  assign romStageWr = wrOk & hitRomCfg;
  assign dbgStageWr = wrOk & hitDbgCfg;
  assign romLockWr  = wrOk & hitRomLock;
  assign dbgKeyWr   = wrOk & hitDbgKey;

  assign romKeyOk  = keyMatch(req.wdata, ROM_PROTECT_KEY);
  assign romCommit = romLockWr & romKeyOk;

  assign dbgKeyOk  = keyMatch(req.wdata, DEBUG_LOCK_KEYW);
  assign dbgCommit = dbgKeyWr & dbgKeyOk;

  // Staging never touches the live enables
  // Runaway code must hit two registers to unlock
  assign romStage_nxt = romStageWr ? req.wdata[ENABLE_BIT] : romStage_r;
  assign dbgStage_nxt = dbgStageWr ? req.wdata[ENABLE_BIT] : dbgStage_r;

  // wrong key ignored
  // Staged value kept, so a retry needs only the key
  assign romGuardNxt = romCommit ? romStage_r : eff_r.romGuardOn;
  assign dbgOffNxt   = dbgCommit ? dbgStage_r : eff_r.debugPortOff;
  assign eff_nxt     = '{romGuardOn: romGuardNxt, debugPortOff: dbgOffNxt};

  assign romCfgWord = enableWord(eff_r.romGuardOn);
  assign dbgCfgWord = enableWord(eff_r.debugPortOff);

  // lock reads fixed
  // Debug key word is write-only and reads as unmapped
  assign rdMux = hitDbgCfg  ? dbgCfgWord      :
                 hitRomCfg  ? romCfgWord      :
                 hitRomLock ? LOCK_READ_VALUE :
                              UNMAPPED_READ;

  // Blocked reads return zero, never the enable
  assign rdata_nxt   = rdOk ? rdMux : UNMAPPED_READ;
  assign blocked_nxt = anyAccess & denied;

  // power-on reset only
  // System reset must not reopen a locked part
  always_ff @(posedge clk) begin
    if (powerOnReset) begin
      eff_r <= '{romGuardOn: ENABLE_RESET, debugPortOff: ENABLE_RESET};
    end else begin
      eff_r <= eff_nxt;
    end
  end

  // Staged protect enable, preset with the live one
  // A lone key write after power-up then changes nothing
  always_ff @(posedge clk) begin
    if (powerOnReset) begin
      romStage_r <= ENABLE_RESET;
    end else begin
      romStage_r <= romStage_nxt;
    end
  end

  // Staged debug-off, preset with the live one
  always_ff @(posedge clk) begin
    if (powerOnReset) begin
      dbgStage_r <= ENABLE_RESET;
    end else begin
      dbgStage_r <= dbgStage_nxt;
    end
  end

  // Bus answer regs follow system reset
  // Read data stand for one cycle only
  always_ff @(posedge clk) begin
    if (reset || powerOnReset) begin
      rdata_r <= UNMAPPED_READ;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Blocked flag is a one-cycle pulse per denied access
  always_ff @(posedge clk) begin
    if (reset || powerOnReset) begin
      blocked_r <= 1'h0;
    end else begin
      blocked_r <= blocked_nxt;
    end
  end

  // Answer outputs
  assign rdata         = rdata_r;
  assign accessBlocked = blocked_r;

  // Live security state
  assign romGuardOn    = eff_r.romGuardOn;
  assign debugPortOff  = eff_r.debugPortOff;

endmodule // rdsl_security_lock

/* File: core/rdsl_pkg.sv */
package rdsl_pkg;

  // Register byte addresses
  localparam logic [31:0] DEBUG_LOCK_CONFIG_ADDR  = 32'hFFFFE510;
  localparam logic [31:0] DEBUG_LOCK_KEY_ADDR     = 32'hFFFFE514;
  localparam logic [31:0] ROM_PROTECT_CONFIG_ADDR = 32'hFFFFE518;
  localparam logic [31:0] ROM_PROTECT_LOCK_ADDR   = 32'hFFFFE51C;

  // Field positions and values
  localparam int          ENABLE_BIT       = 0;
  localparam logic        ENABLE_RESET     = 1'h1;
  localparam logic [31:0] ROM_PROTECT_KEY  = 32'h0000003D;
  localparam logic [31:0] DEBUG_LOCK_KEYW  = 32'h000000C5;
  localparam logic [31:0] UNMAPPED_READ    = 32'h00000000;
  localparam logic [31:0] LOCK_READ_VALUE  = 32'h00000000;

  // Register-bus request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        fromRom;
  } rdsl_req_t;

  // Effective security state
  typedef struct packed {
    logic romGuardOn;
    logic debugPortOff;
  } rdsl_state_t;

endpackage

/* File: tb/rdsl_props.sv */
`timescale 1ns/100ps
module rdsl_props (input wire logic clk, reset, powerOnReset, flashSecure,
  wrStrobe, rdStrobe, fetchFromRom, accessBlocked, romGuardOn, debugPortOff,
  input wire logic [31:0] addr, wdata, rdata);
  default clocking @(posedge clk); endclocking
  default disable iff (powerOnReset || reset);
  wire den = (wrStrobe | rdStrobe) & ~fetchFromRom & (romGuardOn |
    flashSecure) & (addr == 32'hFFFFE518 | addr == 32'hFFFFE51C);
  wire rk = wrStrobe & addr == 32'hFFFFE51C & wdata == 32'h3D & !den;
  wire dk = wrStrobe & addr == 32'hFFFFE514 & wdata == 32'hC5;
  property p_rh; !rk |=> $stable(romGuardOn); endproperty
  a_rh: assert property (p_rh) else $error("guard moved");
  property p_dh; !dk |=> $stable(debugPortOff); endproperty
  a_dh: assert property (p_dh) else $error("debug moved");
  property p_dn; den |=> accessBlocked; endproperty
  a_dn: assert property (p_dn) else $error("not blocked");
  property p_ok; !den |=> !accessBlocked; endproperty
  a_ok: assert property (p_ok) else $error("false block");
  property p_rr; rdStrobe & addr == 32'hFFFFE518 & !den |=>
    rdata == $past(romGuardOn); endproperty
  a_rr: assert property (p_rr) else $error("guard read");
  property p_dr; rdStrobe & addr == 32'hFFFFE510 |=>
    rdata == $past(debugPortOff); endproperty
  a_dr: assert property (p_dr) else $error("debug read");
  property p_po; disable iff (0) powerOnReset |=> romGuardOn & debugPortOff;
  endproperty
  a_po: assert property (p_po) else $error("power-up value");
  property p_rs; disable iff (powerOnReset) reset |=> $stable(romGuardOn);
  endproperty
  a_rs: assert property (p_rs) else $error("reset hit");
endmodule // rdsl_props

/* File: tb/rdsl_security_lock_bench.sv */
`timescale 1ns/100ps
module rdsl_security_lock_bench;
  logic clk = 0, reset = 1, powerOnReset = 1, wrStrobe = 0, rdStrobe = 0;
  logic fetchFromRom = 0, flashSecure = 0, accessBlocked, romGuardOn;
  logic debugPortOff;
  logic [31:0] addr = 0, wdata = 0, rdata;
  localparam logic [32:0] BLK = 33'h100000000;
  int fails = 0, cmp_count = 0;
  always #50 clk = ~clk;
  rdsl_security_lock u_rdsl_security_lock(.clk(clk), .reset(reset),
    .powerOnReset(powerOnReset), .flashSecure(flashSecure), .addr(addr),
    .wdata(wdata), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .fetchFromRom(fetchFromRom), .rdata(rdata),
    .accessBlocked(accessBlocked), .romGuardOn(romGuardOn),
    .debugPortOff(debugPortOff));
  task chk(string n, logic [32:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // Blocked flag rides above the read data
  // whole 32-bit words only
  task op(string n, bit w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    {wrStrobe, rdStrobe, addr, wdata} <= {w, !w, 24'hFFFFE5, a, d};
    @(posedge clk) {wrStrobe, rdStrobe} <= 2'h0;
    #1 chk(n, {accessBlocked, rdata}, e);
    @(posedge clk);
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk);
    {reset, powerOnReset} <= 2'h0;
    @(posedge clk);
    op("guardOut", 0, 8'h18, 0, BLK);
    op("debugCfg", 0, 8'h10, 0, 1);
    fetchFromRom <= 1;
    op("guardCfg", 0, 8'h18, 0, 1);
    op("stage", 1, 8'h18, 0, 0);
    op("wrongKey", 1, 8'h1C, 32'h3C, 0);
    op("pending", 0, 8'h18, 0, 1);
    op("key", 1, 8'h1C, 32'h3D, 0);
    op("commit", 0, 8'h18, 0, 0);
    fetchFromRom <= 0;
    flashSecure <= 1;
    op("flashBlk", 0, 8'h18, 0, BLK);
    flashSecure <= 0;
    op("lockRead", 0, 8'h1C, 0, 0);
    op("dStage", 1, 8'h10, 0, 0);
    op("dKey", 1, 8'h14, 32'hC5, 0);
    op("dCommit", 0, 8'h10, 0, 0);
    reset <= 1;
    @(posedge clk) reset <= 0;
    @(posedge clk) #1 chk("sysReset", {romGuardOn, debugPortOff}, 0);
    powerOnReset <= 1;
    @(posedge clk) powerOnReset <= 0;
    @(posedge clk) #1 chk("powerUp", {romGuardOn, debugPortOff}, 3);
    @(posedge clk);
    op("blockCfg", 1, 8'h18, 0, BLK);
    fetchFromRom <= 1;
    op("keyRom", 1, 8'h1C, 32'h3D, 0);
    op("stillOn", 0, 8'h18, 0, 1);
    complete_run;
  end
endmodule // rdsl_security_lock_bench
bind rdsl_security_lock rdsl_props u_rdsl_props(.*);
